// File: rtl/rts_pkg.sv
// constants, register map and mode types of the ramp-time select and stop control
//
// Contract
// - two terminal select functions form code {sel2,sel1}; 00..11 pick ramp pairs a..d
// - nonzero switch-over frequency: pair a below it, pair d at or above
// - any assigned terminal select function overrides the frequency switch-over
// - jog up and down times set the zero-to-max ramp during jog
// - terminal run source: function 6 jogs forward, 7 reverse, at jog speed
// - function 14 decelerates to stop with emergency time and raises halt flag
// - halt clears only after run command and emergency input both removed
// - function 15 cuts output drive at once, motor coasts
// - polarity 0 maps analog span 0..100 percent, 1 maps 100..0, both inputs
// - application codes 0..7 accepted; writing 0 runs init code 11
// - applications 1, 2 and 5 rewrite their preset values, e.g. pump 2.0/15.0 s
// - each ramp time spans zero to full maximum output frequency
`default_nettype none

package rts_pkg;

    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 5;
    localparam int          NCFG            = 21;

    localparam int          CLK_HZ          = 50_000_000;
    localparam int          TICK_HZ         = 1000;
    localparam int          TICK_CYCLES     = CLK_HZ / TICK_HZ;
    // ramp times count in tenths of a second
    localparam int          TICKS_PER_TENTH = TICK_HZ / 10;

    localparam logic [4:0]  IDX_UP_A        = 5'h00;
    localparam logic [4:0]  IDX_JOG_SPEED   = 5'h08;
    localparam logic [4:0]  IDX_JOG_UP      = 5'h09;
    localparam logic [4:0]  IDX_JOG_DOWN    = 5'h0a;
    localparam logic [4:0]  IDX_EMERG_TIME  = 5'h0b;
    localparam logic [4:0]  IDX_POLARITY    = 5'h0c;
    localparam logic [4:0]  IDX_APP         = 5'h0d;
    localparam logic [4:0]  IDX_SWITCH_FREQ = 5'h0e;
    localparam logic [4:0]  IDX_MAX_FREQ    = 5'h0f;
    localparam logic [4:0]  IDX_RUN_SRC     = 5'h10;
    localparam logic [4:0]  IDX_RUN_CTRL    = 5'h11;
    localparam logic [4:0]  IDX_REF_SRC     = 5'h12;
    localparam logic [4:0]  IDX_TERM_LO     = 5'h13;
    localparam logic [4:0]  IDX_TERM_HI     = 5'h14;
    localparam logic [4:0]  IDX_STATUS      = 5'h15;
    localparam logic [4:0]  IDX_OUT_FREQ    = 5'h16;
    localparam logic [4:0]  IDX_REF_FREQ    = 5'h17;
    localparam logic [4:0]  IDX_INIT_CODE   = 5'h18;

    localparam logic [15:0] CFG_RESET [0:NCFG-1] = '{
        16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064,
        16'h0258, 16'h0064, 16'h0064, 16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h1770,
        16'h0001, 16'h0000, 16'h0000, 16'h3820, 16'h794f};
    localparam logic [15:0] CFG_MASK [0:NCFG-1] = '{
        16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0001, 16'h0007, 16'hffff, 16'hffff,
        16'h0001, 16'h0003, 16'h0001, 16'h7fff, 16'h7fff};

    localparam logic [4:0]  FN_RUN_FWD      = 5'h00;
    localparam logic [4:0]  FN_RUN_REV      = 5'h01;
    localparam logic [4:0]  FN_JOG_FWD      = 5'h06;
    localparam logic [4:0]  FN_JOG_REV      = 5'h07;
    localparam logic [4:0]  FN_RAMP_SEL1    = 5'h0a;
    localparam logic [4:0]  FN_ESTOP        = 5'h0e;
    localparam logic [4:0]  FN_BASE_BLOCK   = 5'h0f;
    localparam logic [4:0]  FN_RAMP_SEL2    = 5'h1e;

    localparam logic [2:0]  APP_GENERAL     = 3'h0;
    localparam logic [2:0]  APP_PUMP        = 3'h1;
    localparam logic [2:0]  APP_CONVEYOR    = 3'h2;
    localparam logic [2:0]  APP_COMPRESSOR  = 3'h5;
    localparam logic [15:0] INIT_2W_60HZ    = 16'h000b;
    localparam logic [15:0] PUMP_UP_TIME    = 16'h0014;
    localparam logic [15:0] PUMP_DOWN_TIME  = 16'h0096;
    localparam logic [15:0] CONVEYOR_TIME   = 16'h001e;
    localparam logic [15:0] COMPRESSOR_TIME = 16'h0032;
    localparam logic [15:0] RUN_SRC_TERM    = 16'h0001;

    typedef enum logic [2:0] {
        RTS_IDLE  = 3'b000,
        RTS_RUN   = 3'b001,
        RTS_JOG   = 3'b010,
        RTS_HALT  = 3'b011,
        RTS_COAST = 3'b100
    } rts_mode_t;

endpackage : rts_pkg

`default_nettype wire

// File: rtl/rts_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none

module rts_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         arst_n_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule : rts_sync

`default_nettype wire

// File: rtl/rts_ramp_step.sv
// per-tick ramp increment in 16.16 fixed point
`default_nettype none

module rts_ramp_step (
    input  wire logic [15:0] fmax_in,
    input  wire logic [15:0] time_in,
    output var  logic [31:0] step_out
);

    wire logic [31:0] num;
    wire logic [31:0] den;
    wire logic [31:0] quot;

    assign num      = {fmax_in, 16'h0000};
    assign den      = 32'(time_in) * 32'(rts_pkg::TICKS_PER_TENTH);
    // zero time means jump in one tick
    assign quot     = (den == 32'h0) ? num : num / den;
    assign step_out = (quot == 32'h0) ? 32'h0000_0001 : quot;

endmodule : rts_ramp_step

`default_nettype wire

// File: rtl/rts_ramp_ctrl.sv
// ramp-time select and stop control top
`default_nettype none

module rts_ramp_ctrl #(
    parameter int NTERM       = 6,
    parameter int ADC_W       = 12,
    parameter int TICK_CYCLES = rts_pkg::TICK_CYCLES
) (
    input  wire logic                      clk_in,
    input  wire logic                      arst_n_in,
    input  wire logic [rts_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [rts_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                      wr_en_in,
    input  wire logic                      rd_en_in,
    output var  logic [rts_pkg::DATA_W-1:0] rd_data_out,
    input  wire logic [NTERM-1:0]          term_in,
    input  wire logic [ADC_W-1:0]          analog_ref_one_in,
    input  wire logic [ADC_W-1:0]          analog_ref_two_in,
    output var  logic [15:0]               out_freq_out,
    output var  logic                      drive_en_out,
    output var  logic                      dir_rev_out,
    output var  logic                      emergency_halt_flag_out,
    output var  logic [1:0]                ramp_pair_out,
    output var  logic [2:0]                mode_out
);

    localparam logic [ADC_W-1:0] ADC_FULL = {ADC_W{1'b1}};
    localparam int               TCW      = $clog2(TICK_CYCLES + 1);

    logic [15:0]        cfg_q [0:rts_pkg::NCFG-1];
    logic [15:0]        init_code_q;
    logic [NTERM-1:0]   term_s;
    logic [ADC_W-1:0]   ana_one_s;
    logic [ADC_W-1:0]   ana_two_s;
    logic [TCW-1:0]     tick_cnt_q;
    logic [31:0]        freq_q;
    logic [31:0]        freq_d;
    logic               halt_q;
    logic               drive_en_q;
    logic               dir_q;
    logic [1:0]         pair_q;
    rts_pkg::rts_mode_t mode_q;
    rts_pkg::rts_mode_t mode_d;
    logic [15:0]        up_time;
    logic [15:0]        down_time;
    logic [15:0]        target;
    logic [31:0]        step_up;
    logic [31:0]        step_down;

    rts_sync #(.W(NTERM)) u_sync_term (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .d_in      (term_in),
        .q_out     (term_s)
    );

    rts_sync #(.W(2 * ADC_W)) u_sync_adc (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .d_in      ({analog_ref_two_in, analog_ref_one_in}),
        .q_out     ({ana_two_s, ana_one_s})
    );

    // terminal function decode
    function automatic logic fn_hit(input logic [5*NTERM-1:0] codes,
                                    input logic [NTERM-1:0]   lvl,
                                    input logic [4:0]         code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NTERM; i++) begin
            if (codes[5*i +: 5] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : fn_hit

    wire logic [29:0] term_codes = {cfg_q[rts_pkg::IDX_TERM_HI][14:0],
                                    cfg_q[rts_pkg::IDX_TERM_LO][14:0]};
    wire logic [NTERM-1:0] all_on = {NTERM{1'b1}};

    wire logic run_src_term = cfg_q[rts_pkg::IDX_RUN_SRC][0];
    wire logic run_fwd  = run_src_term ? fn_hit(term_codes, term_s, rts_pkg::FN_RUN_FWD)
                                       : cfg_q[rts_pkg::IDX_RUN_CTRL][0];
    wire logic run_rev  = run_src_term ? fn_hit(term_codes, term_s, rts_pkg::FN_RUN_REV)
                                       : cfg_q[rts_pkg::IDX_RUN_CTRL][1];
    wire logic jog_fwd  = run_src_term & fn_hit(term_codes, term_s, rts_pkg::FN_JOG_FWD);
    wire logic jog_rev  = run_src_term & fn_hit(term_codes, term_s, rts_pkg::FN_JOG_REV);
    wire logic estop_act = fn_hit(term_codes, term_s, rts_pkg::FN_ESTOP);
    wire logic bb_act    = fn_hit(term_codes, term_s, rts_pkg::FN_BASE_BLOCK);
    wire logic sel1_on   = fn_hit(term_codes, term_s, rts_pkg::FN_RAMP_SEL1);
    wire logic sel2_on   = fn_hit(term_codes, term_s, rts_pkg::FN_RAMP_SEL2);
    wire logic sel_assigned = fn_hit(term_codes, all_on, rts_pkg::FN_RAMP_SEL1)
                            | fn_hit(term_codes, all_on, rts_pkg::FN_RAMP_SEL2);
    wire logic run_req = run_fwd | run_rev;
    wire logic jog_req = jog_fwd | jog_rev;

    // halt latch: set by the input, kept while any run command stays
    wire logic halt_d = estop_act | (halt_q & (run_req | jog_req));

    always_comb begin
        if (bb_act) begin
            mode_d = rts_pkg::RTS_COAST;
        end else if (halt_d) begin
            mode_d = rts_pkg::RTS_HALT;
        end else if (run_req) begin
            mode_d = rts_pkg::RTS_RUN;
        end else if (jog_req) begin
            mode_d = rts_pkg::RTS_JOG;
        end else begin
            mode_d = rts_pkg::RTS_IDLE;
        end
    end

    // ramp pair selection
    wire logic [15:0] freq_int  = freq_q[31:16];
    wire logic [15:0] sw_freq   = cfg_q[rts_pkg::IDX_SWITCH_FREQ];
    wire logic [1:0]  auto_pair = (sw_freq != 16'h0 && freq_int >= sw_freq) ? 2'b11 : 2'b00;
    wire logic [1:0]  pair_sel  = sel_assigned ? {sel2_on, sel1_on} : auto_pair;
    wire logic [4:0]  up_idx    = {2'b00, pair_sel, 1'b0};
    wire logic [4:0]  down_idx  = {2'b00, pair_sel, 1'b1};

    // analog reference mapping
    wire logic        pol     = cfg_q[rts_pkg::IDX_POLARITY][0];
    wire logic [ADC_W-1:0] map_one = pol ? ADC_FULL - ana_one_s : ana_one_s;
    wire logic [ADC_W-1:0] map_two = pol ? ADC_FULL - ana_two_s : ana_two_s;
    wire logic [ADC_W-1:0] ref_raw = cfg_q[rts_pkg::IDX_REF_SRC][0] ? map_two : map_one;
    wire logic [15:0] fmax    = cfg_q[rts_pkg::IDX_MAX_FREQ];
    wire logic [31:0] ref_prod = 32'(ref_raw) * 32'(fmax);
    wire logic [31:0] ref_quot = ref_prod / 32'(ADC_FULL);
    wire logic [15:0] ref_freq = ref_quot[15:0];

    always_comb begin
        case (mode_q)
            rts_pkg::RTS_RUN: begin
                target    = ref_freq;
                up_time   = cfg_q[up_idx];
                down_time = cfg_q[down_idx];
            end
            rts_pkg::RTS_JOG: begin
                target    = cfg_q[rts_pkg::IDX_JOG_SPEED];
                up_time   = cfg_q[rts_pkg::IDX_JOG_UP];
                down_time = cfg_q[rts_pkg::IDX_JOG_DOWN];
            end
            rts_pkg::RTS_HALT: begin
                target    = 16'h0000;
                up_time   = cfg_q[rts_pkg::IDX_EMERG_TIME];
                down_time = cfg_q[rts_pkg::IDX_EMERG_TIME];
            end
            default: begin
                target    = 16'h0000;
                up_time   = cfg_q[up_idx];
                down_time = cfg_q[down_idx];
            end
        endcase
    end

    rts_ramp_step u_step_up (
        .fmax_in  (fmax),
        .time_in  (up_time),
        .step_out (step_up)
    );

    rts_ramp_step u_step_down (
        .fmax_in  (fmax),
        .time_in  (down_time),
        .step_out (step_down)
    );

    wire logic        tick  = (tick_cnt_q == TCW'(TICK_CYCLES - 1));
    wire logic [31:0] tgt   = {target, 16'h0000};
    wire logic [31:0] gap_u = tgt - freq_q;
    wire logic [31:0] gap_d = freq_q - tgt;

    always_comb begin
        freq_d = freq_q;
        if (mode_q == rts_pkg::RTS_COAST) begin
            freq_d = 32'h0;
        end else if (tick && freq_q < tgt) begin
            freq_d = (gap_u <= step_up) ? tgt : freq_q + step_up;
        end else if (tick && freq_q > tgt) begin
            freq_d = (gap_d <= step_down) ? tgt : freq_q - step_down;
        end
    end

    wire logic drive_en_d = ~bb_act & ((mode_d == rts_pkg::RTS_RUN)
                          | (mode_d == rts_pkg::RTS_JOG) | (freq_q != 32'h0));
    // direction only changes while standing still
    wire logic dir_cmd = (mode_d == rts_pkg::RTS_RUN) ? (run_rev & ~run_fwd)
                       : (mode_d == rts_pkg::RTS_JOG) ? (jog_rev & ~jog_fwd) : dir_q;
    wire logic dir_d   = (freq_int == 16'h0) ? dir_cmd : dir_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tick_cnt_q <= '0;
            freq_q     <= 32'h0;
            halt_q     <= 1'b0;
            drive_en_q <= 1'b0;
            dir_q      <= 1'b0;
            pair_q     <= 2'b00;
            mode_q     <= rts_pkg::RTS_IDLE;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + TCW'(1);
            freq_q     <= freq_d;
            halt_q     <= halt_d;
            drive_en_q <= drive_en_d;
            dir_q      <= dir_d;
            pair_q     <= pair_sel;
            mode_q     <= mode_d;
        end
    end

    // register file and application presets
    wire logic       wr_cfg  = wr_en_in && (addr_in < 5'(rts_pkg::NCFG));
    wire logic       wr_app  = wr_en_in && (addr_in == rts_pkg::IDX_APP);
    wire logic [2:0] app_val = wr_data_in[2:0];

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < rts_pkg::NCFG; i++) begin
                cfg_q[i] <= rts_pkg::CFG_RESET[i];
            end
            init_code_q <= 16'h0000;
        end else if (wr_app) begin
            cfg_q[rts_pkg::IDX_APP] <= {13'h0000, app_val};
            case (app_val)
                rts_pkg::APP_GENERAL: begin
                    for (int i = 0; i < rts_pkg::NCFG; i++) begin
                        cfg_q[i] <= rts_pkg::CFG_RESET[i];
                    end
                    init_code_q <= rts_pkg::INIT_2W_60HZ;
                end
                rts_pkg::APP_PUMP: begin
                    cfg_q[rts_pkg::IDX_UP_A]      <= rts_pkg::PUMP_UP_TIME;
                    cfg_q[rts_pkg::IDX_UP_A + 1]  <= rts_pkg::PUMP_DOWN_TIME;
                end
                rts_pkg::APP_CONVEYOR: begin
                    cfg_q[rts_pkg::IDX_UP_A]      <= rts_pkg::CONVEYOR_TIME;
                    cfg_q[rts_pkg::IDX_UP_A + 1]  <= rts_pkg::CONVEYOR_TIME;
                end
                rts_pkg::APP_COMPRESSOR: begin
                    cfg_q[rts_pkg::IDX_UP_A]      <= rts_pkg::COMPRESSOR_TIME;
                    cfg_q[rts_pkg::IDX_UP_A + 1]  <= rts_pkg::COMPRESSOR_TIME;
                    cfg_q[rts_pkg::IDX_RUN_SRC]   <= rts_pkg::RUN_SRC_TERM;
                    cfg_q[rts_pkg::IDX_TERM_LO]   <= rts_pkg::CFG_RESET[rts_pkg::IDX_TERM_LO];
                end
                default: begin
                end
            endcase
        end else if (wr_cfg) begin
            cfg_q[addr_in] <= wr_data_in & rts_pkg::CFG_MASK[addr_in];
        end
    end

    wire logic [15:0] status = {9'h000, halt_q, drive_en_q, dir_q, pair_q,
                                mode_q == rts_pkg::RTS_JOG, mode_q == rts_pkg::RTS_COAST};
    wire logic [15:0] rd_mux = (addr_in < 5'(rts_pkg::NCFG))    ? cfg_q[addr_in]
                             : (addr_in == rts_pkg::IDX_STATUS)    ? status
                             : (addr_in == rts_pkg::IDX_OUT_FREQ)  ? freq_int
                             : (addr_in == rts_pkg::IDX_REF_FREQ)  ? ref_freq
                             : (addr_in == rts_pkg::IDX_INIT_CODE) ? init_code_q : 16'h0000;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_out <= 16'h0000;
        end else begin
            rd_data_out <= rd_en_in ? rd_mux : 16'h0000;
        end
    end

    assign out_freq_out            = freq_q[31:16];
    assign drive_en_out            = drive_en_q;
    assign dir_rev_out             = dir_q;
    assign emergency_halt_flag_out = halt_q;
    assign ramp_pair_out           = pair_q;
    assign mode_out                = mode_q;

    property p_sel_code;
        @(posedge clk_in) disable iff (!arst_n_in)
        sel_assigned |=> ramp_pair_out == $past({sel2_on, sel1_on});
    endproperty
    a_sel_code: assert property (p_sel_code) else $error("terminal ramp pair wrong");

    property p_auto_pair;
        @(posedge clk_in) disable iff (!arst_n_in)
        (!sel_assigned && sw_freq != 16'h0) |=> pair_q == {2{$past(freq_int >= sw_freq)}};
    endproperty
    a_auto_pair: assert property (p_auto_pair) else $error("switch-over pair wrong");

    property p_override;
        @(posedge clk_in) disable iff (!arst_n_in)
        (sel_assigned && !sel1_on && !sel2_on) |=> ramp_pair_out == 2'b00;
    endproperty
    a_override: assert property (p_override) else $error("terminal select lost priority");

    property p_jog_times;
        @(posedge clk_in) disable iff (!arst_n_in)
        mode_q == rts_pkg::RTS_JOG |-> up_time == cfg_q[rts_pkg::IDX_JOG_UP]
            && down_time == cfg_q[rts_pkg::IDX_JOG_DOWN];
    endproperty
    a_jog_times: assert property (p_jog_times) else $error("jog ramp times not used");

    property p_jog_target;
        @(posedge clk_in) disable iff (!arst_n_in)
        (jog_fwd && !run_req && !halt_d && !bb_act)
            |=> mode_out == rts_pkg::RTS_JOG && target == cfg_q[rts_pkg::IDX_JOG_SPEED];
    endproperty
    a_jog_target: assert property (p_jog_target) else $error("jog not entered");

    property p_estop;
        @(posedge clk_in) disable iff (!arst_n_in)
        (estop_act && !bb_act)
            |=> emergency_halt_flag_out && mode_out == rts_pkg::RTS_HALT && target == 16'h0;
    endproperty
    a_estop: assert property (p_estop) else $error("emergency stop not taken");

    property p_halt_hold;
        @(posedge clk_in) disable iff (!arst_n_in)
        (halt_q && (run_req || jog_req)) |=> emergency_halt_flag_out;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt cleared with run held");

    property p_halt_clear;
        @(posedge clk_in) disable iff (!arst_n_in)
        (halt_q && !run_req && !jog_req && !estop_act) |=> !emergency_halt_flag_out;
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt not cleared");

    property p_coast;
        @(posedge clk_in) disable iff (!arst_n_in)
        bb_act |=> !drive_en_out ##1 (out_freq_out == 16'h0 || !drive_en_out);
    endproperty
    a_coast: assert property (p_coast) else $error("drive on during base block");

    property p_polarity;
        @(posedge clk_in) disable iff (!arst_n_in)
        map_one + (pol ? ana_one_s : ADC_FULL - ana_one_s) == ADC_FULL
            && map_two + (pol ? ana_two_s : ADC_FULL - ana_two_s) == ADC_FULL;
    endproperty
    a_polarity: assert property (p_polarity) else $error("reference polarity wrong");

    property p_init;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_app && app_val == '0) |=> init_code_q == 16'h000b && fmax == 16'h1770;
    endproperty
    a_init: assert property (p_init) else $error("init not executed");

    property p_pump;
        @(posedge clk_in) disable iff (!arst_n_in)
        (wr_app && app_val == rts_pkg::APP_PUMP) |=> cfg_q[0] == 16'h0014 && cfg_q[1] == 16'h0096;
    endproperty
    a_pump: assert property (p_pump) else $error("pump preset not applied");

    property p_run_times;
        @(posedge clk_in) disable iff (!arst_n_in)
        mode_q == rts_pkg::RTS_RUN |-> up_time == cfg_q[{2'b00, pair_sel, 1'b0}];
    endproperty
    a_run_times: assert property (p_run_times) else $error("pair ramp time not used");

    property p_ramp_up;
        @(posedge clk_in) disable iff (!arst_n_in)
        (tick && mode_q != rts_pkg::RTS_COAST && freq_q < tgt)
            |=> freq_q == $past(freq_q) + $past(step_up) || freq_q == $past(tgt);
    endproperty
    a_ramp_up: assert property (p_ramp_up) else $error("ramp step wrong");

endmodule : rts_ramp_ctrl

`default_nettype wire

// File: sim/rts_terminal_model.sv
// terminal contacts and analog source facing the drive
`default_nettype none
module rts_terminal_model (
    input  wire logic        clk_in,
    input  wire logic [5:0]  pins_in,
    input  wire logic [11:0] level_in,
    output var  logic [5:0]  term_out,
    output var  logic [11:0] ana_one_out,
    output var  logic [11:0] ana_two_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        term_out    = '0;
        ana_one_out = '0;
        ana_two_out = '1;
    end
    // contacts switch just after the edge; input two carries the inverse level
    always @(posedge clk_in) begin
        term_out    <= pins_in;
        ana_one_out <= level_in;
        ana_two_out <= ~level_in;
    end
endmodule : rts_terminal_model
`default_nettype wire

// File: sim/rts_ramp_ctrl_tb_top.sv
// register and terminal tests of the ramp control
`default_nettype none
module rts_ramp_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 0, arst_n_in = 0, wr_en = 0, rd_en = 0;
    logic [4:0]  addr = '0;
    logic [15:0] wdata = '0, rdata, freq;
    logic [5:0]  pins = '0, term;
    logic [11:0] level = '0, a1, a2;
    logic        drive, dir, halt;
    logic [1:0]  pair;
    logic [2:0]  mode;
    int          fails = 0, checks_done = 0;
    always #10 clk_in = ~clk_in;
    rts_terminal_model u_rts_terminal_model (.clk_in(clk_in), .pins_in(pins),
        .level_in(level), .term_out(term), .ana_one_out(a1), .ana_two_out(a2));
    rts_ramp_ctrl #(.TICK_CYCLES(20)) u_rts_ramp_ctrl (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .rd_data_out(rdata), .term_in(term), .analog_ref_one_in(a1),
        .analog_ref_two_in(a2), .out_freq_out(freq), .drive_en_out(drive),
        .dir_rev_out(dir), .emergency_halt_flag_out(halt), .ramp_pair_out(pair),
        .mode_out(mode));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_en <= 1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr_en <= 0;
    endtask : wr
    task rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        rd_en <= 1;
        addr  <= a;
        @(posedge clk_in);
        rd_en <= 0;
        #1 chk(rdata, exp);
    endtask : rd
    task pin_wait(input logic [5:0] p, input int n);
        @(posedge clk_in);
        pins <= p;
        repeat (n) @(posedge clk_in);
        #1;
    endtask : pin_wait
    task results;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        #400us;
        fails++;
        results;
    end
    initial begin
        repeat (12) @(posedge clk_in);
        arst_n_in <= 1;
        rd(5'h00, 16'h0064);
        rd(5'h0f, 16'h1770);
        rd(5'h13, 16'h3820);
        rd(5'h19, 16'h0000);
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            pin_wait({i[1:0], 4'h0}, 5);
            chk({14'h0, pair}, i[15:0]);
        end
        $display("test terminal pair done");
        wr(5'h14, 16'h7fef);
        wr(5'h0e, 16'h0001);
        wr(5'h00, 16'h0001);
        wr(5'h06, 16'h0001);
        level <= 12'hfff;
        pin_wait(6'h01, 2500);
        chk({14'h0, pair}, 16'h0003);
        chk(freq, 16'h1770);
        $display("test switch-over done");
        wr(5'h0b, 16'h0001);
        pin_wait(6'h05, 5);
        chk({12'h0, halt, mode}, 16'h000b);
        pin_wait(6'h05, 2500);
        chk(freq, 16'h0000);
        pin_wait(6'h01, 5);
        chk({12'h0, halt, mode}, 16'h000b);
        pin_wait(6'h00, 5);
        chk({12'h0, halt, mode}, 16'h0000);
        $display("test emergency stop done");
        pin_wait(6'h01, 300);
        pin_wait(6'h09, 5);
        chk({drive, mode, freq[11:0]}, 16'h4000);
        pin_wait(6'h00, 5);
        $display("test coast done");
        level <= 12'h000;
        wr(5'h0c, 16'h0001);
        repeat (5) @(posedge clk_in);
        rd(5'h17, 16'h1770);
        wr(5'h0c, 16'h0000);
        repeat (5) @(posedge clk_in);
        rd(5'h17, 16'h0000);
        $display("test polarity done");
        wr(5'h13, 16'h38e6);
        pin_wait(6'h01, 5);
        chk({13'h0, mode}, 16'h0002);
        pin_wait(6'h00, 5);
        pin_wait(6'h02, 5);
        chk({12'h0, dir, mode}, 16'h000a);
        pin_wait(6'h00, 5);
        $display("test jog done");
        wr(5'h0d, 16'h0001);
        rd(5'h00, 16'h0014);
        rd(5'h01, 16'h0096);
        wr(5'h0d, 16'h0002);
        rd(5'h01, 16'h001e);
        wr(5'h0d, 16'h0005);
        rd(5'h00, 16'h0032);
        rd(5'h0d, 16'h0005);
        wr(5'h0d, 16'h0000);
        rd(5'h18, 16'h000b);
        rd(5'h00, 16'h0064);
        $display("test presets done");
        results;
    end
endmodule : rts_ramp_ctrl_tb_top
`default_nettype wire
